// ### logic/bsr_regs.svh
// register map, field positions, reset values and timing figures of the
// basic system register bank
// assumes a wishbone word bus: byte address = printed index times four
`ifndef BSR_REGS_SVH
`define BSR_REGS_SVH

// printed register indices
`define BSR_IX_STATUS     5'h00
`define BSR_IX_MISC       5'h1C
`define BSR_IX_REALTIME_COUNTER      5'h1D
`define BSR_IX_VIO_INDEX  5'h1E
`define BSR_IX_VIRTUAL_PORT_DATA   5'h1F

// status low byte
`define BSR_ST_ZERO       0
`define BSR_ST_CARRY      1
`define BSR_ST_OVF        2
`define BSR_ST_NEG        3
`define BSR_ST_QUOT       4
`define BSR_ST_IRQ_EN     7
`define BSR_ST_LO_RST     8'h20
`define BSR_ST_LO_WMASK   8'h9F
`define BSR_ST_LO_FIXED   8'h20
// status high byte
`define BSR_ST_SPIM       0
`define BSR_ST_SPIS       1
`define BSR_ST_PWIN       3
`define BSR_ST_VWIN       5
`define BSR_ST_FBUF       6
`define BSR_ST_PQUE       7
`define BSR_ST_HI_RST     8'h00
`define BSR_ST_HI_WMASK   8'h2B

// misc low byte
`define BSR_MI_WDT        0
`define BSR_MI_LV         1
`define BSR_MI_PIN        2
`define BSR_MI_RC         3
`define BSR_MI_MUTE       5
`define BSR_MI_LO_RST     8'h00
`define BSR_MI_LO_WMASK   8'h2F
// misc high byte
`define BSR_MI_TCS        0
`define BSR_MI_REG        1
`define BSR_MI_WIDE       2
`define BSR_MI_CLR        7
`define BSR_MI_HI_RST     8'h00
`define BSR_MI_HI_WMASK   8'h07

// virtual programming indices and reset values
`define BSR_VIO_OD_A      8'h05
`define BSR_VIO_OD_B      8'h06
`define BSR_VIO_OD_RST    8'h00

// timing: clock period and counter timebase period, in picoseconds
`define BSR_CLK_PERIOD_PS 40000
`define BSR_RTC_PERIOD_PS 30517

`endif

// ### logic/bsr_pkg.sv
// types shared by the basic system register bank modules
// assumes nothing of its surroundings
package bsr_pkg;

   // which half of the real-time counter the next read returns
   typedef enum logic {
      BSR_SEQ_LOW,
      BSR_SEQ_HIGH
   } bsr_seq_t;

endpackage : bsr_pkg

// ### logic/bsr_rtc_if.sv
// carrier between the register bank and its real-time counter
// assumes both ends run on the same clock
interface bsr_rtc_if;
   logic        run;
   logic        clear;
   logic        seq_reset;
   logic        seq_step;
   logic [15:0] word;

   modport ctrl (
      output run,
      output clear,
      output seq_reset,
      output seq_step,
      input  word
   );
   modport timer (
      input  run,
      input  clear,
      input  seq_reset,
      input  seq_step,
      output word
   );
endinterface : bsr_rtc_if

// ### logic/bsr_rtc.sv
// 32-bit real-time counter with a fractional timebase and word sequencer
// assumes one clock; the timebase period may be shorter than the clock
`include "bsr_regs.svh"

module bsr_rtc
   import bsr_pkg::*;
#(
   parameter int CLK_PS  = `BSR_CLK_PERIOD_PS,
   parameter int TICK_PS = `BSR_RTC_PERIOD_PS
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   bsr_rtc_if.timer  rtc
);

   localparam int ACC_W = $clog2(CLK_PS + 2 * TICK_PS + 1);

   if (CLK_PS < 1 || TICK_PS < 1 || CLK_PS >= 2 * TICK_PS) begin : g_chk
      $error("bsr_rtc: timebase needs at most two ticks per clock");
   end

   logic [ACC_W-1:0] acc;
   logic [ACC_W-1:0] sum;
   logic [ACC_W-1:0] next_acc;
   logic [1:0]       inc;
   logic [31:0]      count;
   logic [15:0]      snap;
   bsr_seq_t         seq;

   // --------------------------------------------------------------
   // timebase: phase accumulator in picoseconds
   // --------------------------------------------------------------
   always_comb begin
      sum = acc + ACC_W'(CLK_PS);
      if (sum >= ACC_W'(2 * TICK_PS)) begin
         inc      = 2'h2;
         next_acc = sum - ACC_W'(2 * TICK_PS);
      end else if (sum >= ACC_W'(TICK_PS)) begin
         inc      = 2'h1;
         next_acc = sum - ACC_W'(TICK_PS);
      end else begin
         inc      = 2'h0;
         next_acc = sum;
      end
   end

   // phase and count: clear only while running, frozen while stopped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc   <= '0;
         count <= 32'h0000_0000;
      end else if (rtc.run && rtc.clear) begin
         acc   <= '0;
         count <= 32'h0000_0000;
      end else if (rtc.run) begin
         acc   <= next_acc;
         count <= count + {30'h0000_0000, inc};
      end
   end

   // --------------------------------------------------------------
   // read sequencer: low word first, high word snapped with it
   // --------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq  <= BSR_SEQ_LOW;
         snap <= 16'h0000;
      end else if (rtc.seq_reset) begin
         seq <= BSR_SEQ_LOW;
      end else if (rtc.seq_step) begin
         case (seq)
            BSR_SEQ_LOW: begin
               seq  <= BSR_SEQ_HIGH;
               snap <= count[31:16];
            end
            default: begin
               seq <= BSR_SEQ_LOW;
            end
         endcase
      end
   end

   assign rtc.word = (seq == BSR_SEQ_LOW) ? count[15:0] : snap;

endmodule : bsr_rtc

// ### logic/bsr_bank.sv
// basic system register bank: status flags, system controls, misc
// register with reset causes and real-time counter, virtual port writes
// assumes a classic wishbone master on clk_i and single-cycle result
// strobes from the computational units
//
// The Wishbone register port is this design's own decision.
`include "bsr_regs.svh"

// What this block does
// - keep zero, negative, overflow, carry flags in status low byte
// - zero flag set when the result equals zero, else cleared
// - negative flag follows the sign of the result
// - parser and filter availability bits are read-only
// - status low bit 7 gates every interrupt request
// - two control bits open vector and priority table windows
// - status high bit 0 enables the spi master
// - another status control bit enables the spi slave
// - real-time counter runs only while its enable bit is 1
// - counter is 32 bits, one step per 30.517 ns timebase period
// - write to counter port restarts reads: low word then high
// - misc high bit 7 clears the counter, only while enabled
// - regulator enable bit drives the regulator request output
// - in sleep, request forced off on b variant, kept on c
// - filter select: 0 narrowband, 1 wideband
// - misc low bit 5 mutes audio pwm
// - reset-cause flags: rc bit 3, pin 2, low voltage 1, watchdog 0
// - rc, pin or low-voltage reset clears watchdog flag unless set
// - software may set and clear each reset-cause flag
// - software setting a cause flag never resets the device
// - virtual indices 05 and 06 hold port a and b open-drain enables
// - counter read and write-reset through address 1d
module bsr_bank
   import bsr_pkg::*;
#(
   parameter int ADR_W        = 7,
   parameter int PORT_A_W     = 8,
   parameter int PORT_B_W     = 8,
   parameter bit SLEEP_KEEPS_REG = 1'b1
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // wishbone slave
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [ADR_W-1:0]    adr_i,
   input  wire logic [3:0]          sel_i,
   input  wire logic [31:0]         dat_i,
   output logic      [31:0]         dat_o,
   output logic                     ack_o,
   // computational unit results
   input  wire logic                calc_valid_i,
   input  wire logic [15:0]         calc_result_i,
   input  wire logic                calc_overflow_i,
   input  wire logic                calc_carry_i,
   input  wire logic                calc_quotient_i,
   // live indications
   input  wire logic                parser_queue_avail_i,
   input  wire logic                filter_buffer_avail_i,
   input  wire logic                irq_request_i,
   input  wire logic                sleep_mode_i,
   // reset-cause events
   input  wire logic                rc_reset_event_i,
   input  wire logic                pin_reset_event_i,
   input  wire logic                low_voltage_event_i,
   input  wire logic                watchdog_event_i,
   // controls
   output logic                     irq_o,
   output logic                     global_irq_enable_o,
   output logic                     vector_table_window_o,
   output logic                     priority_table_window_o,
   output logic                     spi_master_enable_o,
   output logic                     spi_slave_enable_o,
   output logic                     audio_mute_o,
   output logic                     filter_wideband_o,
   output logic                     regulator_on_o,
   output logic                     realtime_counter_enable_o,
   output logic [PORT_A_W-1:0]      port_a_open_drain_o,
   output logic [PORT_B_W-1:0]      port_b_open_drain_o,
   output logic                     vio_write_o,
   output logic [7:0]               vio_index_o,
   output logic [15:0]              virtual_port_data_o
);

   if (ADR_W < 7 || PORT_A_W < 1 || PORT_A_W > 16 ||
       PORT_B_W < 1 || PORT_B_W > 16) begin : g_chk
      $error("bsr_bank: address or port width out of range");
   end

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   // byte-lane merge of one register byte under a write mask
   function automatic logic [7:0] merge_byte(
      input logic [7:0] old_v,
      input logic [7:0] new_v,
      input logic [7:0] wmask
   );
      merge_byte = (old_v & ~wmask) | (new_v & wmask);
   endfunction : merge_byte

   // register index hit for the current address
   function automatic logic is_ix(
      input logic [ADR_W-1:0] adr,
      input logic [4:0]       ix
   );
      is_ix = (adr[ADR_W-1:2] == (ADR_W-2)'(ix));
   endfunction : is_ix

   // --------------------------------------------------------------
   // declarations
   // --------------------------------------------------------------
   logic        req;
   logic        wr;
   logic        rd;
   logic        wr_lo;
   logic        wr_hi;
   logic [7:0]  status_lo;
   logic [7:0]  status_hi;
   logic [7:0]  misc_lo;
   logic [7:0]  misc_hi;
   logic [7:0]  next_status_lo;
   logic [7:0]  next_status_hi;
   logic [7:0]  next_misc_lo;
   logic [7:0]  next_misc_hi;
   logic        parser_queue_avail;
   logic        filter_buffer_avail;
   logic        rtc_clear;
   logic [7:0]  virtual_port_index;
   logic [31:0] next_rdata;
   logic        any_reset_event;

   bsr_rtc_if rtc_bus ();

   // --------------------------------------------------------------
   // wishbone decode: one wait state, ack for every address
   // --------------------------------------------------------------
   assign req   = cyc_i && stb_i && !ack_o;
   assign wr    = req && we_i;
   assign rd    = req && !we_i;
   assign wr_lo = wr && sel_i[0];
   assign wr_hi = wr && sel_i[1];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   // --------------------------------------------------------------
   // status register
   // --------------------------------------------------------------
   // low byte: software write, then unit results override
   always_comb begin
      next_status_lo = status_lo;
      if (wr_lo && is_ix(adr_i, `BSR_IX_STATUS)) begin
         next_status_lo = merge_byte(status_lo, dat_i[7:0], `BSR_ST_LO_WMASK) |
                          `BSR_ST_LO_FIXED;
      end
      if (calc_valid_i) begin
         next_status_lo[`BSR_ST_ZERO]  = (calc_result_i == 16'h0000);
         next_status_lo[`BSR_ST_NEG]   = calc_result_i[15];
         next_status_lo[`BSR_ST_OVF]   = calc_overflow_i;
         next_status_lo[`BSR_ST_CARRY] = calc_carry_i;
         next_status_lo[`BSR_ST_QUOT]  = calc_quotient_i;
      end
   end

   // high byte: only the control bits are writable
   always_comb begin
      next_status_hi = status_hi;
      if (wr_hi && is_ix(adr_i, `BSR_IX_STATUS)) begin
         next_status_hi = merge_byte(status_hi, dat_i[15:8],
                                     `BSR_ST_HI_WMASK);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_lo <= `BSR_ST_LO_RST;
         status_hi <= `BSR_ST_HI_RST;
      end else begin
         status_lo <= next_status_lo;
         status_hi <= next_status_hi;
      end
   end

   // availability bits mirror the live inputs, never software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         parser_queue_avail  <= 1'b0;
         filter_buffer_avail <= 1'b0;
      end else begin
         parser_queue_avail  <= parser_queue_avail_i;
         filter_buffer_avail <= filter_buffer_avail_i;
      end
   end

   // --------------------------------------------------------------
   // misc register
   // --------------------------------------------------------------
   assign any_reset_event = rc_reset_event_i || pin_reset_event_i ||
                            low_voltage_event_i;

   // low byte: software write, then cause events (events win)
   always_comb begin
      next_misc_lo = misc_lo;
      if (wr_lo && is_ix(adr_i, `BSR_IX_MISC)) begin
         // flag update only, no reset is issued from here
         next_misc_lo = merge_byte(misc_lo, dat_i[7:0],
                                   `BSR_MI_LO_WMASK);
      end
      if (any_reset_event && !watchdog_event_i) begin
         next_misc_lo[`BSR_MI_WDT] = 1'b0;
      end
      if (rc_reset_event_i) begin
         next_misc_lo[`BSR_MI_RC] = 1'b1;
      end
      if (pin_reset_event_i) begin
         next_misc_lo[`BSR_MI_PIN] = 1'b1;
      end
      if (low_voltage_event_i) begin
         next_misc_lo[`BSR_MI_LV] = 1'b1;
      end
      if (watchdog_event_i) begin
         next_misc_lo[`BSR_MI_WDT] = 1'b1;
      end
   end

   // high byte: stored controls; the clear bit is a write pulse
   always_comb begin
      next_misc_hi = misc_hi;
      if (wr_hi && is_ix(adr_i, `BSR_IX_MISC)) begin
         next_misc_hi = merge_byte(misc_hi, dat_i[15:8], `BSR_MI_HI_WMASK);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         misc_lo <= `BSR_MI_LO_RST;
         misc_hi <= `BSR_MI_HI_RST;
      end else begin
         misc_lo <= next_misc_lo;
         misc_hi <= next_misc_hi;
      end
   end

   // clear request takes effect only with the counter enabled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rtc_clear <= 1'b0;
      end else begin
         rtc_clear <= wr_hi && is_ix(adr_i, `BSR_IX_MISC) &&
                      dat_i[8 + `BSR_MI_CLR] &&
                      next_misc_hi[`BSR_MI_TCS];
      end
   end

   // --------------------------------------------------------------
   // real-time counter
   // --------------------------------------------------------------
   assign rtc_bus.run       = misc_hi[`BSR_MI_TCS];
   assign rtc_bus.clear     = rtc_clear;
   assign rtc_bus.seq_reset = wr && is_ix(adr_i, `BSR_IX_REALTIME_COUNTER);
   assign rtc_bus.seq_step  = rd && is_ix(adr_i, `BSR_IX_REALTIME_COUNTER);

   bsr_rtc #(
      .CLK_PS  (`BSR_CLK_PERIOD_PS),
      .TICK_PS (`BSR_RTC_PERIOD_PS)
   ) u_rtc (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .rtc   (rtc_bus.timer)
   );

   // --------------------------------------------------------------
   // virtual programming port
   // --------------------------------------------------------------
   // index is latched first, data then lands at that index
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         virtual_port_index <= 8'h00;
      end else if (wr_lo && is_ix(adr_i, `BSR_IX_VIO_INDEX)) begin
         virtual_port_index <= dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_a_open_drain_o <= PORT_A_W'(`BSR_VIO_OD_RST);
         port_b_open_drain_o <= PORT_B_W'(`BSR_VIO_OD_RST);
      end else if (wr && is_ix(adr_i, `BSR_IX_VIRTUAL_PORT_DATA)) begin
         if (virtual_port_index == `BSR_VIO_OD_A) begin
            port_a_open_drain_o <= dat_i[PORT_A_W-1:0];
         end else if (virtual_port_index == `BSR_VIO_OD_B) begin
            port_b_open_drain_o <= dat_i[PORT_B_W-1:0];
         end
      end
   end

   // every data write is also announced to the virtual space outside
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vio_write_o <= 1'b0;
         vio_index_o <= 8'h00;
         virtual_port_data_o  <= 16'h0000;
      end else begin
         vio_write_o <= wr && is_ix(adr_i, `BSR_IX_VIRTUAL_PORT_DATA);
         if (wr && is_ix(adr_i, `BSR_IX_VIRTUAL_PORT_DATA)) begin
            vio_index_o <= virtual_port_index;
            virtual_port_data_o  <= dat_i[15:0];
         end
      end
   end

   // --------------------------------------------------------------
   // read data
   // --------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (is_ix(adr_i, `BSR_IX_STATUS)) begin
         next_rdata[7:0]  = status_lo;
         next_rdata[15:8] = status_hi;
         next_rdata[8 + `BSR_ST_PQUE] = parser_queue_avail;
         next_rdata[8 + `BSR_ST_FBUF] = filter_buffer_avail;
      end else if (is_ix(adr_i, `BSR_IX_MISC)) begin
         next_rdata[7:0]  = misc_lo;
         next_rdata[15:8] = misc_hi;
      end else if (is_ix(adr_i, `BSR_IX_REALTIME_COUNTER)) begin
         next_rdata[15:0] = rtc_bus.word;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd) begin
         dat_o <= next_rdata;
      end
   end

   // --------------------------------------------------------------
   // control outputs, one flop each
   // --------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o                     <= 1'b0;
         global_irq_enable_o       <= 1'b0;
         vector_table_window_o     <= 1'b0;
         priority_table_window_o   <= 1'b0;
         spi_master_enable_o       <= 1'b0;
         spi_slave_enable_o        <= 1'b0;
      end else begin
         irq_o                   <= irq_request_i && status_lo[`BSR_ST_IRQ_EN];
         global_irq_enable_o     <= status_lo[`BSR_ST_IRQ_EN];
         vector_table_window_o   <= status_hi[`BSR_ST_VWIN];
         priority_table_window_o <= status_hi[`BSR_ST_PWIN];
         spi_master_enable_o     <= status_hi[`BSR_ST_SPIM];
         spi_slave_enable_o      <= status_hi[`BSR_ST_SPIS];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         audio_mute_o              <= 1'b0;
         filter_wideband_o         <= 1'b0;
         regulator_on_o            <= 1'b0;
         realtime_counter_enable_o <= 1'b0;
      end else begin
         audio_mute_o      <= misc_lo[`BSR_MI_MUTE];
         filter_wideband_o <= misc_hi[`BSR_MI_WIDE];
         // sleep keeps the request only on the variant that allows it
         regulator_on_o    <= misc_hi[`BSR_MI_REG] &&
                              (!sleep_mode_i || SLEEP_KEEPS_REG);
         realtime_counter_enable_o <= misc_hi[`BSR_MI_TCS];
      end
   end

endmodule : bsr_bank

// ### verif/bsr_bank_asserts.sv
// concurrent checks on the ports of the basic system register bank
// assumes one clock clk_i and a synchronous active-high reset rst_i
module bsr_bank_asserts #(
   parameter bit SLEEP_KEEPS_REG = 1'b1
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [6:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        irq_request_i,
   input wire logic        sleep_mode_i,
   input wire logic        irq_o,
   input wire logic        global_irq_enable_o,
   input wire logic        spi_master_enable_o,
   input wire logic        regulator_on_o,
   input wire logic        vio_write_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ----------------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------------
   property p_ack_once;
      ack_o |=> !ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("ack held longer than one cycle");
   property p_ack_resp;
      cyc_i && stb_i && !ack_o |=> ack_o;
   endproperty
   a_ack_resp: assert property (p_ack_resp)
      else $error("request not answered in the next cycle");
   property p_ack_req;
      ack_o |-> $past(cyc_i && stb_i);
   endproperty
   a_ack_req: assert property (p_ack_req)
      else $error("ack without a request");
   property p_dat_hi;
      ack_o |-> dat_o[31:16] == 16'h0000;
   endproperty
   a_dat_hi: assert property (p_dat_hi)
      else $error("upper read lanes not zero");

   // ----------------------------------------------------------------
   // control outputs
   // ----------------------------------------------------------------
   property p_irq;
      irq_o == ($past(irq_request_i) && global_irq_enable_o);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not gated by the global enable");
   property p_reg_sleep;
      !SLEEP_KEEPS_REG && regulator_on_o |-> !$past(sleep_mode_i);
   endproperty
   a_reg_sleep: assert property (p_reg_sleep)
      else $error("regulator request on during sleep");
   property p_vio;
      vio_write_o |-> $past(we_i && adr_i[6:2] == 5'h1F);
   endproperty
   a_vio: assert property (p_vio)
      else $error("virtual write pulse without a data write");
   property p_spim;
      $changed(spi_master_enable_o) |-> $past(we_i) || $past(we_i, 2) || $past(we_i, 3);
   endproperty
   a_spim: assert property (p_spim)
      else $error("spi master enable changed without a write");
endmodule : bsr_bank_asserts

bind bsr_bank bsr_bank_asserts #(.SLEEP_KEEPS_REG(SLEEP_KEEPS_REG)) u_chk (.clk_i, .rst_i,
   .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .irq_request_i, .sleep_mode_i, .irq_o,
   .global_irq_enable_o, .spi_master_enable_o, .regulator_on_o, .vio_write_o);

// ### verif/bsr_bank_tb.sv
// self-checking bench for the basic system register bank
// assumes the b variant (regulator off in sleep) and a 7-bit byte address
module bsr_bank_tb;
   import bsr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, irq_o;
   logic [6:0]  adr_i = 0;
   logic [3:0]  sel_i = 0;
   logic [31:0] dat_i = 0, dat_o, rd;
   logic        calc_valid_i = 0, calc_overflow_i = 0, calc_carry_i = 0, calc_quotient_i = 0;
   logic [15:0] calc_result_i = 0, virtual_port_data_o;
   logic        parser_queue_avail_i = 0, filter_buffer_avail_i = 0, irq_request_i = 0;
   logic        sleep_mode_i = 0, rc_reset_event_i = 0, pin_reset_event_i = 0;
   logic        low_voltage_event_i = 0, watchdog_event_i = 0, vio_write_o;
   logic        global_irq_enable_o, vector_table_window_o, priority_table_window_o;
   logic        spi_master_enable_o, spi_slave_enable_o, audio_mute_o, filter_wideband_o;
   logic        regulator_on_o, realtime_counter_enable_o;
   logic [7:0]  port_a_open_drain_o, port_b_open_drain_o, vio_index_o;
   logic [15:0] res [3] = '{16'h0000, 16'h8000, 16'h1234};
   int          miscompares = 0, comparisons = 0, lo, d, r0;

   bsr_bank #(.SLEEP_KEEPS_REG(1'b0)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .calc_valid_i, .calc_result_i, .calc_overflow_i,
      .calc_carry_i, .calc_quotient_i, .parser_queue_avail_i, .filter_buffer_avail_i,
      .irq_request_i, .sleep_mode_i, .rc_reset_event_i, .pin_reset_event_i,
      .low_voltage_event_i, .watchdog_event_i, .irq_o, .global_irq_enable_o,
      .vector_table_window_o, .priority_table_window_o, .spi_master_enable_o,
      .spi_slave_enable_o, .audio_mute_o, .filter_wideband_o, .regulator_on_o,
      .realtime_counter_enable_o, .port_a_open_drain_o, .port_b_open_drain_o,
      .vio_write_o, .vio_index_o, .virtual_port_data_o);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // one classic bus cycle; read data taken at the edge where ack is seen
   task automatic wb(input logic w, input logic [4:0] ix, input logic [31:0] wd);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {ix, 2'b00};
      sel_i <= 4'hF;
      dat_i <= wd;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask : wb
   // one-cycle pulse on the reset-cause events {rc, pin, low voltage, watchdog}
   task automatic ev(input logic [3:0] e);
      @(posedge clk_i);
      {rc_reset_event_i, pin_reset_event_i, low_voltage_event_i, watchdog_event_i} <= e;
      @(posedge clk_i);
      {rc_reset_event_i, pin_reset_event_i, low_voltage_event_i, watchdog_event_i} <= 4'h0;
   endtask : ev
   task automatic results;
      if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------------------------------
   initial forever #20 clk_i = ~clk_i;
   initial begin
      #200000;
      miscompares++;
      results();
   end
   initial begin
      r0 = $urandom(11550);
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 5'h00, 0); cmp(rd, 32'h20);
      wb(0, 5'h1C, 0); cmp(rd, 32'h0);
      // status writes with the live bits opposite to the written ones
      repeat (4) begin
         d = $urandom;
         parser_queue_avail_i <= ~d[15];
         filter_buffer_avail_i <= ~d[14];
         irq_request_i <= d[20];
         wb(1, 5'h00, d);
         lo = d & 'h9F | 'h20;
         wb(0, 5'h00, 0); cmp(rd, (~d & 'hC000) | (d & 'h2B00) | lo);
         cmp({global_irq_enable_o, vector_table_window_o, priority_table_window_o,
              spi_slave_enable_o, spi_master_enable_o}, {d[7], d[13], d[11], d[9], d[8]});
         cmp(irq_o, d[20] & d[7]);
      end
      // result strobes from the computational units
      foreach (res[i]) begin
         d = $urandom;
         @(posedge clk_i);
         calc_valid_i <= 1'b1;
         calc_result_i <= res[i];
         {calc_quotient_i, calc_overflow_i, calc_carry_i} <= d[2:0];
         @(posedge clk_i);
         calc_valid_i <= 1'b0;
         lo = lo & 'hE0 | d[2] << 4 | res[i][15] << 3 | d[1] << 2 | d[0] << 1 | (res[i] == 0);
         wb(0, 5'h00, 0); cmp(rd[7:0], lo[7:0]);
      end
      // misc controls and reset causes, counter kept off
      d = $urandom & 'h062F;
      wb(1, 5'h1C, d);
      wb(0, 5'h1C, 0); cmp(rd, d);
      cmp({audio_mute_o, filter_wideband_o, regulator_on_o}, {d[5], d[10], d[9]});
      ev(4'b0001);
      ev(4'b0100);
      d = d & ~1 | 4;
      wb(0, 5'h1C, 0); cmp(rd, d);
      ev(4'b1001);
      d = d | 9;
      wb(0, 5'h1C, 0); cmp(rd, d);
      wb(1, 5'h1C, d | 'h200);
      sleep_mode_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      cmp(regulator_on_o, 0);
      sleep_mode_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      cmp(regulator_on_o, 1);
      // counter: enable and clear, run, freeze, read in halves
      wb(1, 5'h1C, 'h8100);
      repeat (20) @(posedge clk_i);
      cmp(realtime_counter_enable_o, 1);
      wb(1, 5'h1C, 'h8000);
      wb(0, 5'h1C, 0); cmp(rd, 0);
      wb(1, 5'h1D, 0);
      wb(0, 5'h1D, 0);
      r0 = rd;
      wb(0, 5'h1D, 0); cmp(rd, 0);
      cmp(r0 >= 20 && r0 <= 40, 1);
      wb(1, 5'h1D, 0);
      wb(0, 5'h1D, 0); cmp(rd, r0);
      // virtual port writes to both open-drain indices
      for (int i = 0; i < 2; i++) begin
         d = $urandom & 'hFFFF;
         wb(1, 5'h1E, 5 + i);
         wb(1, 5'h1F, d);
         cmp(vio_write_o, 1);
         repeat (2) @(posedge clk_i);
         cmp({vio_index_o, virtual_port_data_o}, {8'(5 + i), d[15:0]});
         cmp(i ? port_b_open_drain_o : port_a_open_drain_o, d[7:0]);
      end
      wb(0, 5'h1F, 0); cmp(rd, 0);
      wb(0, 5'h10, 0); cmp(rd, 0);
      results();
   end
endmodule : bsr_bank_tb
